// ===== logic/pau_top.sv
// process alarm unit: registers, latch clear sources, interrupt, channels
//
// Function
// - separate hysteresis per alarm, own output only
// - hysteresis defaults 0.2 deg or 0.02% FS
// - standby holds alarm until leave and re-entry
// - lower alarm at power-up stays off under standby
// - first assertion ends standby condition
// - standby re-armed per restart select setting
// - latched alarm holds until latch clear
// - power-down or entry to initial, comms, advanced or calibration level clears latch
// - function key or event input clears latch
`timescale 1ns/1ns
`default_nettype none
module pau_top (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic signed [pau_pkg::PV_W-1:0] i_pv,
  input wire logic i_input_analog,
  input wire logic i_function_key,
  input wire logic i_event_latch_cancel,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic [pau_pkg::NUM_ALARM-1:0] o_alarm,
  output logic o_irq
);
  localparam int N = pau_pkg::NUM_ALARM;

  logic [31:0] ctrl;
  pau_pkg::pau_level_e level;
  logic signed [pau_pkg::PV_W-1:0] setpt [N];
  logic [pau_pkg::PV_W-1:0] hyst [N];
  logic [N-1:0] irq_stat;
  logic [N-1:0] irq_mask;
  logic [N-1:0] standby;
  logic [N-1:0] rise;
  logic [N-1:0] setpt_wr;
  logic [N-1:0] alarm_fall;
  logic [2:0] key_sync;
  logic [2:0] evt_sync;
  logic [1:0] strap_sync;
  logic [1:0] init_cnt;
  logic key_edge;
  logic evt_edge;
  logic level_clr;
  logic latch_clr;
  logic [2:0] wr_level;
  pau_pkg::pau_restart_e restart_sel;
  logic [31:0] next_rdata;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_sync <= 3'h0;
      evt_sync <= 3'h0;
      strap_sync <= 2'h0;
    end else begin
      key_sync <= {key_sync[1:0], i_function_key};
      evt_sync <= {evt_sync[1:0], i_event_latch_cancel};
      strap_sync <= {strap_sync[0], i_input_analog};
    end
  end

  assign key_edge = key_sync[1] && !key_sync[2];
  assign evt_edge = evt_sync[1] && !evt_sync[2];

  // ****************************************
  // control and level registers
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= pau_pkg::CTRL_RST;
    end else if (i_wr && i_addr == pau_pkg::ADDR_CTRL) begin
      ctrl <= i_wdata;
    end
  end

  assign restart_sel = pau_pkg::pau_restart_e'(
    ctrl[pau_pkg::CTRL_RESTART_BIT]);
  assign wr_level = i_wdata[2:0];

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level <= pau_pkg::PAU_LVL_OPERATION;
    end else if (i_wr && i_addr == pau_pkg::ADDR_LEVEL) begin
      level <= pau_pkg::pau_level_e'(wr_level);
    end
  end

  // entry into initial, comms, advanced or calibration level
  always_comb begin
    level_clr = 1'b0;
    if (i_wr && i_addr == pau_pkg::ADDR_LEVEL && wr_level != level) begin
      case (pau_pkg::pau_level_e'(wr_level))
        pau_pkg::PAU_LVL_INITIAL: level_clr = 1'b1;
        pau_pkg::PAU_LVL_COMMS: level_clr = 1'b1;
        pau_pkg::PAU_LVL_ADVANCED: level_clr = 1'b1;
        pau_pkg::PAU_LVL_CALIB: level_clr = 1'b1;
        default: level_clr = 1'b0;
      endcase
    end
  end

  // power-down clears the latch through the async reset
  assign latch_clr = level_clr
    || (key_edge && ctrl[pau_pkg::CTRL_KEY_EN_BIT])
    || (evt_edge && ctrl[pau_pkg::CTRL_EVT_EN_BIT]);

  // ****************************************
  // strap capture for default hysteresis
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_cnt <= 2'h0;
    end else if (init_cnt != 2'h3) begin
      init_cnt <= init_cnt + 2'h1;
    end
  end

  // ****************************************
  // per-alarm registers and channels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      localparam logic [7:0] SP_ADDR =
        8'(pau_pkg::ADDR_SETPT0 + g * pau_pkg::ADDR_STRIDE);
      localparam logic [7:0] HY_ADDR =
        8'(pau_pkg::ADDR_HYST0 + g * pau_pkg::ADDR_STRIDE);
      pau_pkg::pau_ch_cfg_s cfg;
      pau_pkg::pau_ch_ctl_s ctl;

      assign setpt_wr[g] = i_wr && (i_addr == SP_ADDR || i_addr == HY_ADDR);

      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          setpt[g] <= pau_pkg::SETPT_RST;
        end else if (i_wr && i_addr == SP_ADDR) begin
          setpt[g] <= i_wdata[pau_pkg::PV_W-1:0];
        end
      end

      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          hyst[g] <= pau_pkg::HYST_TEMP_RST;
        end else if (i_wr && i_addr == HY_ADDR) begin
          hyst[g] <= i_wdata[pau_pkg::PV_W-1:0];
        end else if (init_cnt == 2'h2) begin
          hyst[g] <= strap_sync[1] ? pau_pkg::HYST_ANALOG_RST
                                   : pau_pkg::HYST_TEMP_RST;
        end
      end

      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          alarm_fall[g] <= 1'b0;
        end else begin
          alarm_fall[g] <= o_alarm[g] && !cfg.latch_en && !rise[g];
        end
      end

      assign cfg.setpt = setpt[g];
      assign cfg.hyst = hyst[g];
      assign cfg.lower = ctrl[pau_pkg::CTRL_LOWER_LSB + g];
      assign cfg.standby_en = ctrl[pau_pkg::CTRL_STBY_LSB + g];
      assign cfg.latch_en = ctrl[pau_pkg::CTRL_LATCH_LSB + g];
      // re-arm on new setting, or also when an unlatched output drops
      assign ctl.rearm = setpt_wr[g]
        || (restart_sel == pau_pkg::PAU_RESTART_ALSO_OFF
            && alarm_fall[g] && !o_alarm[g]);
      assign ctl.latch_clr = latch_clr;

      pau_alarm_ch u_ch (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_pv(i_pv),
        .i_cfg(cfg),
        .i_ctl(ctl),
        .o_alarm(o_alarm[g]),
        .o_standby(standby[g]),
        .o_rise(rise[g])
      );
    end
  endgenerate

  // ****************************************
  // interrupt status and mask
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask <= pau_pkg::MASK_RST;
    end else if (i_wr && i_addr == pau_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= i_wdata[N-1:0];
    end
  end

  // a read clears, a new rising edge in the same cycle wins
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat <= 3'h0;
    end else if (i_rd && i_addr == pau_pkg::ADDR_IRQ_STAT) begin
      irq_stat <= rise;
    end else begin
      irq_stat <= irq_stat | rise;
    end
  end

  assign o_irq = |(irq_stat & irq_mask);

  // ****************************************
  // read port
  // ****************************************
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      pau_pkg::ADDR_CTRL: next_rdata = ctrl;
      pau_pkg::ADDR_LEVEL: next_rdata = {29'h0, level};
      pau_pkg::ADDR_STATE: begin
        next_rdata[N-1:0] = o_alarm;
        next_rdata[pau_pkg::STATE_STBY_LSB +: N] = standby;
      end
      pau_pkg::ADDR_IRQ_STAT: next_rdata[N-1:0] = irq_stat;
      pau_pkg::ADDR_IRQ_MASK: next_rdata[N-1:0] = irq_mask;
      default: begin
        for (int k = 0; k < N; k++) begin
          if (i_addr == 8'(pau_pkg::ADDR_SETPT0
                           + k * pau_pkg::ADDR_STRIDE)) begin
            next_rdata = {{16{setpt[k][pau_pkg::PV_W-1]}}, setpt[k]};
          end
          if (i_addr == 8'(pau_pkg::ADDR_HYST0
                           + k * pau_pkg::ADDR_STRIDE)) begin
            next_rdata = {16'h0000, hyst[k]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_LEVEL_CLR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    level_clr |-> latch_clr)
    else $error("level entry did not clear latch");
  AST_KEY_CLR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(i_function_key) && ctrl[pau_pkg::CTRL_KEY_EN_BIT]
    ##1 ctrl[pau_pkg::CTRL_KEY_EN_BIT] |-> ##1 latch_clr)
    else $error("function key did not clear latch in time");
  AST_HYST_DFLT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    init_cnt == 2'h2 && !i_wr |=> hyst[0] == (strap_sync[1]
      ? pau_pkg::HYST_ANALOG_RST : pau_pkg::HYST_TEMP_RST))
    else $error("hysteresis default not loaded");
  AST_IRQ_STICKY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    |rise |=> |irq_stat)
    else $error("alarm event not recorded");
  COV_LEVEL: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    |o_alarm ##1 level_clr);
  COV_IRQ: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_irq));
endmodule
`default_nettype wire

// ===== logic/pau_pkg.sv
// constants, types and register map of the process alarm unit
package pau_pkg;
  localparam int NUM_ALARM = 3;
  localparam int PV_W = 16;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_SETPT0 = 8'h10;
  localparam logic [7:0] ADDR_HYST0 = 8'h20;
  localparam logic [7:0] ADDR_STATE = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h34;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h38;
  localparam logic [7:0] ADDR_STRIDE = 8'h04;
  // ctrl fields
  localparam int CTRL_STBY_LSB = 0;
  localparam int CTRL_LATCH_LSB = 4;
  localparam int CTRL_LOWER_LSB = 8;
  localparam int CTRL_RESTART_BIT = 12;
  localparam int CTRL_EVT_EN_BIT = 13;
  localparam int CTRL_KEY_EN_BIT = 14;
  localparam int STATE_STBY_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_6000;
  // default hysteresis: 0.2 deg in 0.1 deg steps, 0.02 %FS in 0.01 % steps
  localparam logic [PV_W-1:0] HYST_TEMP_RST = 16'h0002;
  localparam logic [PV_W-1:0] HYST_ANALOG_RST = 16'h0002;
  localparam logic [PV_W-1:0] SETPT_RST = 16'h0000;
  localparam logic [2:0] MASK_RST = 3'h0;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic {
    PAU_RESTART_SETPT,
    PAU_RESTART_ALSO_OFF
  } pau_restart_e;
  typedef enum logic [2:0] {
    PAU_LVL_OPERATION,
    PAU_LVL_ADJUST,
    PAU_LVL_INITIAL,
    PAU_LVL_COMMS,
    PAU_LVL_ADVANCED,
    PAU_LVL_CALIB
  } pau_level_e;
  typedef struct packed {
    logic signed [PV_W-1:0] setpt;
    logic [PV_W-1:0] hyst;
    logic lower;
    logic standby_en;
    logic latch_en;
  } pau_ch_cfg_s;
  typedef struct packed {
    logic rearm;
    logic latch_clr;
  } pau_ch_ctl_s;
endpackage

// ===== logic/pau_alarm_ch.sv
// one alarm channel: hysteresis, standby sequence and latch
`timescale 1ns/1ns
`default_nettype none
module pau_alarm_ch (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic signed [pau_pkg::PV_W-1:0] i_pv,
  input wire pau_pkg::pau_ch_cfg_s i_cfg,
  input wire pau_pkg::pau_ch_ctl_s i_ctl,
  output logic o_alarm,
  output logic o_standby,
  output logic o_rise
);
  logic signed [pau_pkg::PV_W:0] pv_x;
  logic signed [pau_pkg::PV_W:0] sv_x;
  logic signed [pau_pkg::PV_W:0] hy_x;
  logic on_cond;
  logic off_cond;
  logic raw;
  logic left;
  logic standby;
  logic stby_eff;
  logic act_now;
  logic next_alarm;

  assign pv_x = {i_pv[pau_pkg::PV_W-1], i_pv};
  assign sv_x = {i_cfg.setpt[pau_pkg::PV_W-1], i_cfg.setpt};
  assign hy_x = {1'b0, i_cfg.hyst};
  // ****************************************
  // range compare
  // ****************************************
  assign on_cond = i_cfg.lower ? (pv_x < sv_x) : (pv_x > sv_x);
  // release only past the setting by the hysteresis width
  assign off_cond = i_cfg.lower ? (pv_x >= sv_x + hy_x)
                                : (pv_x <= sv_x - hy_x);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      raw <= 1'b0;
    end else if (raw && off_cond) begin
      raw <= 1'b0;
    end else if (!raw && on_cond) begin
      raw <= 1'b1;
    end
  end
  // ****************************************
  // standby sequence
  // ****************************************
  assign stby_eff = standby && i_cfg.standby_en;
  // held off until the value has left the range once
  assign act_now = raw && (!stby_eff || left);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      standby <= 1'b1;
    end else if (i_ctl.rearm) begin
      standby <= 1'b1;
    end else if (next_alarm && !o_alarm) begin
      standby <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left <= 1'b0;
    end else if (i_ctl.rearm) begin
      left <= 1'b0;
    end else if (stby_eff && !on_cond) begin
      left <= 1'b1;
    end
  end
  // ****************************************
  // latch and output
  // ****************************************
  always_comb begin
    next_alarm = act_now;
    if (i_cfg.latch_en && o_alarm && !i_ctl.latch_clr) begin
      next_alarm = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_alarm <= 1'b0;
    end else begin
      o_alarm <= next_alarm;
    end
  end

  assign o_standby = stby_eff;
  assign o_rise = next_alarm && !o_alarm;

  // ****************************************
  // checks
  // ****************************************
  AST_HYST_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    raw && !off_cond |=> raw)
    else $error("alarm released inside hysteresis band");
  AST_STBY_BLOCK: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    stby_eff && !left && !o_alarm && !i_ctl.rearm |-> !o_rise)
    else $error("alarm raised during standby before leaving range");
  AST_LOWER_PWRUP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_cfg.lower && stby_eff && !left && !o_alarm
    ##1 i_cfg.lower && on_cond && !left |-> !o_rise)
    else $error("lower alarm raised at power-up under standby");
  AST_STBY_END: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_rise && !i_ctl.rearm |=> !standby)
    else $error("standby still active after alarm asserted");
  AST_REARM: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_ctl.rearm |=> standby && !left)
    else $error("standby not re-armed");
  AST_LATCH_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_cfg.latch_en && o_alarm && !i_ctl.latch_clr |=> o_alarm)
    else $error("latched alarm dropped without clear");
  AST_NOLATCH: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_cfg.latch_en |=> o_alarm == $past(act_now))
    else $error("unlatched alarm does not follow its own compare");
  COV_RISE: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    stby_eff ##1 left ##[1:50] o_rise);
  COV_LATCH: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_cfg.latch_en && o_alarm && !act_now ##1 o_alarm);
endmodule
`default_nettype wire

// ===== dv/pau_pv_src.sv
// process value source model for the alarm unit
`timescale 1ns/1ns
`default_nettype none
module pau_pv_src (
  input wire logic i_mclk,
  input wire logic signed [pau_pkg::PV_W-1:0] i_target,
  input wire logic [7:0] i_step,
  output logic signed [pau_pkg::PV_W-1:0] o_pv
);
  // ****************************************
  // step or ramp toward the target
  // ****************************************
  logic signed [pau_pkg::PV_W-1:0] step_s;
  logic signed [pau_pkg::PV_W-1:0] diff;
  assign step_s = signed'({8'h00, i_step});
  assign diff = i_target - o_pv;
  initial o_pv = 16'h0000;
  // zero step jumps at once, else a slow ramp through the thresholds
  always @(posedge i_mclk) begin
    if (i_step == 8'h00 || (diff <= step_s && -diff <= step_s)) begin
      o_pv <= i_target;
    end else if (diff > 0) begin
      o_pv <= o_pv + step_s;
    end else begin
      o_pv <= o_pv - step_s;
    end
  end
endmodule
`default_nettype wire

// ===== dv/pau_top_test.sv
// self-checking testbench of the process alarm unit
`timescale 1ns/1ns
`default_nettype none
module pau_top_test;
  logic i_mclk;
  logic i_rst_n;
  logic i_input_analog;
  logic i_function_key;
  logic i_event_latch_cancel;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic [pau_pkg::NUM_ALARM-1:0] o_alarm;
  logic o_irq;
  logic signed [pau_pkg::PV_W-1:0] pv;
  logic signed [pau_pkg::PV_W-1:0] pv_target;
  logic [7:0] pv_step;
  logic [31:0] d;
  int n_fail;
  int check_count;
  pau_pv_src i_pau_pv_src (.i_mclk(i_mclk), .i_target(pv_target),
    .i_step(pv_step), .o_pv(pv));
  pau_top i_pau_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pv(pv),
    .i_input_analog(i_input_analog), .i_function_key(i_function_key),
    .i_event_latch_cancel(i_event_latch_cancel), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_alarm(o_alarm), .o_irq(o_irq));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic results();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_al(input logic [2:0] e);
    chk({29'h0, o_alarm}, {29'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  function automatic logic [7:0] reg_at(input logic [7:0] b, input int c);
    return 8'(b + pau_pkg::ADDR_STRIDE * c);
  endfunction
  task automatic set_pv(input int v, input logic [7:0] s);
    int n;
    n = 0;
    @(posedge i_mclk);
    pv_step <= s;
    pv_target <= 16'(v);
    @(posedge i_mclk);
    while (pv !== 16'(v) && n < 400) begin
      @(posedge i_mclk);
      n++;
    end
    if (n == 400) begin
      n_fail++;
      results();
    end
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  // operator press: key (0) or event input (1)
  task automatic press(input bit ev);
    @(posedge i_mclk);
    if (ev) i_event_latch_cancel <= 1'b1;
    else i_function_key <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_event_latch_cancel <= 1'b0;
    i_function_key <= 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic raise();
    set_pv(120, 8'h00);
    set_pv(50, 8'h00);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    for (int a = 1; a >= 0; a--) begin
      i_input_analog <= a[0];
      do_reset();
      for (int c = 0; c < 3; c++) begin
        chk_rd(reg_at(pau_pkg::ADDR_HYST0, c), {16'h0000, a ?
          pau_pkg::HYST_ANALOG_RST : pau_pkg::HYST_TEMP_RST});
      end
    end
    chk_rd(pau_pkg::ADDR_CTRL, pau_pkg::CTRL_RST);
  endtask
  task automatic t_irq();
    for (int c = 0; c < 3; c++) wr(reg_at(pau_pkg::ADDR_SETPT0, c), 32'h64);
    rd(pau_pkg::ADDR_IRQ_STAT);
    wr(pau_pkg::ADDR_IRQ_MASK, 32'h1);
    set_pv(120, 8'h00);
    chk_al(3'h7);
    chk({31'h0, o_irq}, 32'h1);
    chk_rd(pau_pkg::ADDR_IRQ_STAT, 32'h7);
    chk({31'h0, o_irq}, 32'h0);
    chk_rd(pau_pkg::ADDR_IRQ_STAT, 32'h0);
    wr(pau_pkg::ADDR_IRQ_MASK, 32'h0);
    raise();
    set_pv(120, 8'h00);
    chk({31'h0, o_irq}, 32'h0);
    chk_rd(pau_pkg::ADDR_IRQ_STAT, 32'h7);
    chk_rd(8'hFC, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    chk_rd(pau_pkg::ADDR_CTRL, pau_pkg::CTRL_RST);
  endtask
  task automatic t_hyst();
    wr(pau_pkg::ADDR_HYST0, 32'h5);
    set_pv(90, 8'h00);
    set_pv(100, 8'h00);
    chk_al(3'h0);
    set_pv(101, 8'h00);
    chk_al(3'h7);
    set_pv(98, 8'h00);
    chk_al(3'h1);
    set_pv(96, 8'h00);
    chk_al(3'h1);
    set_pv(95, 8'h00);
    chk_al(3'h0);
    set_pv(120, 8'h01);
    chk_al(3'h7);
  endtask
  task automatic t_standby();
    set_pv(50, 8'h00);
    do_reset();
    wr(pau_pkg::ADDR_CTRL, 32'h0000_6404);
    wr(reg_at(pau_pkg::ADDR_SETPT0, 2), 32'h64);
    set_pv(50, 8'h00);
    chk({31'h0, o_alarm[2]}, 32'h0);
    // alarms 0 and 1 keep setting 0 after reset, so 50 is above them
    chk_rd(pau_pkg::ADDR_STATE, 32'h0000_0043);
    chk({31'h0, d[6]}, 32'h1);
    set_pv(120, 8'h00);
    set_pv(90, 8'h00);
    chk({31'h0, o_alarm[2]}, 32'h1);
    rd(pau_pkg::ADDR_STATE);
    chk({31'h0, d[6]}, 32'h0);
    set_pv(120, 8'h00);
    rd(pau_pkg::ADDR_STATE);
    chk({31'h0, d[6]}, 32'h0);
    set_pv(90, 8'h00);
    chk({31'h0, o_alarm[2]}, 32'h1);
    set_pv(120, 8'h00);
    wr(reg_at(pau_pkg::ADDR_SETPT0, 2), 32'h64);
    rd(pau_pkg::ADDR_STATE);
    chk({31'h0, d[6]}, 32'h1);
    set_pv(90, 8'h00);
    wr(pau_pkg::ADDR_CTRL, 32'h0000_7404);
    set_pv(120, 8'h00);
    rd(pau_pkg::ADDR_STATE);
    chk({31'h0, d[6]}, 32'h1);
  endtask
  task automatic t_latch();
    wr(reg_at(pau_pkg::ADDR_SETPT0, 0), 32'h64);
    wr(pau_pkg::ADDR_CTRL, 32'h0000_6010);
    raise();
    // alarm 1 has setting 0 and no latch: on while the value is 50
    chk({30'h0, o_alarm[1:0]}, 32'h3);
    press(1'b0);
    chk({31'h0, o_alarm[0]}, 32'h0);
    wr(pau_pkg::ADDR_CTRL, 32'h0000_2010);
    raise();
    press(1'b0);
    chk({31'h0, o_alarm[0]}, 32'h1);
    press(1'b1);
    chk({31'h0, o_alarm[0]}, 32'h0);
    for (int lv = 1; lv <= 5; lv++) begin
      wr(pau_pkg::ADDR_LEVEL, 32'h0);
      raise();
      wr(pau_pkg::ADDR_LEVEL, 32'(lv));
      repeat (2) @(posedge i_mclk);
      #1;
      chk({31'h0, o_alarm[0]}, {31'h0, lv == 1});
    end
    raise();
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    #1;
    chk({28'h0, o_irq, o_alarm}, 32'h0);
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    chk_rd(pau_pkg::ADDR_CTRL, pau_pkg::CTRL_RST);
  endtask
  // ****************************************
  // clock and main sequence
  // ****************************************
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    n_fail = 0;
    check_count = 0;
    i_rst_n = 1'b0;
    i_input_analog = 1'b0;
    i_function_key = 1'b0;
    i_event_latch_cancel = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    pv_target = 16'h0000;
    pv_step = 8'h00;
    t_reset();
    t_irq();
    t_hyst();
    t_standby();
    t_latch();
    results();
  end
endmodule
`default_nettype wire
